/* File: design/acc_pkg.sv */
// constants, types and field layouts for the converter control block
package acc_pkg;
  localparam int ADDR_W = 8;
  localparam int RES_W = 10;
  localparam int RES_DROP = 2;
  localparam logic [7:0] OFF_SC1 = 8'h00;
  localparam logic [7:0] OFF_SC2 = 8'h04;
  localparam logic [7:0] OFF_RESHI = 8'h08;
  localparam logic [7:0] OFF_RESLO = 8'h0c;
  localparam logic [7:0] OFF_CMPV = 8'h10;
  localparam logic [7:0] OFF_CFG = 8'h14;
  localparam logic [7:0] ADDR_LSB_MASK = 8'h03;
  localparam logic [4:0] CH_EXT_LAST = 5'h0f;
  localparam logic [4:0] CH_GND_LAST = 5'h15;
  localparam logic [4:0] CH_TEMP = 5'h1a;
  localparam logic [4:0] CH_BG = 5'h1b;
  localparam logic [4:0] CH_VREFH = 5'h1d;
  localparam logic [4:0] CH_VREFL = 5'h1e;
  localparam logic [4:0] CH_OFF = 5'h1f;
  localparam logic [9:0] SAR_MSB = 10'h200;
  localparam logic [9:0] LOW8_MASK = 10'h0ff;
  localparam logic [3:0] BIT_TOP = 4'h9;
  localparam logic [4:0] SMP_SHORT_LIM = 5'h03;
  localparam logic [4:0] SMP_LONG_LIM = 5'h17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CLK_BUS = 2'b00, CLK_BUS2 = 2'b01, CLK_ALT = 2'b10, CLK_ASYNC = 2'b11
  } acc_clksrc_t;
  typedef enum logic [2:0] {
    K_EXT = 3'b000, K_GND = 3'b001, K_RSVD = 3'b010, K_TEMP = 3'b011,
    K_BG = 3'b100, K_VREFH = 3'b101, K_VREFL = 3'b110, K_OFF = 3'b111
  } acc_kind_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_SAMPLE = 2'b01, S_CONV = 2'b10
  } acc_state_t;
  typedef struct packed {
    logic conversion_complete_flag;
    logic aien;
    logic cont;
    logic [4:0] ch;
  } acc_sc1_t;
  typedef struct packed {
    logic active;
    logic hwtrig;
    logic cmp_en;
    logic cmp_ge;
    logic [2:0] pad;
    logic bg_ok;
  } acc_sc2_t;
  typedef struct packed {
    logic low_power;
    logic [1:0] div;
    logic long_smp;
    logic res10;
    logic pad;
    acc_clksrc_t clk;
  } acc_cfg_t;
endpackage

/* File: design/acc_ctrl.sv */
// converter control: register slave, clock select, trigger, SAR sequencer
`timescale 1ns/100ps
module acc_ctrl #(
  parameter int ADDR_W = acc_pkg::ADDR_W
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic ASYNC_TICK,
  input wire logic ALT_TICK,
  input wire logic STOP3_MODE,
  input wire logic HW_TRIG,
  input wire logic BANDGAP_BUF_EN,
  input wire logic CMP_IN,
  output logic [4:0] AN_SEL,
  output logic [2:0] AN_KIND,
  output logic AN_CONNECT,
  output logic AN_SAMPLE,
  output logic [9:0] DAC_CODE,
  output logic LOW_POWER,
  output logic IRQ
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  acc_pkg::acc_sc1_t sc1_reg, sc1_next;
  acc_pkg::acc_sc2_t sc2_reg;
  acc_pkg::acc_cfg_t cfg_reg;
  acc_pkg::acc_state_t state_reg, state_next;
  logic [9:0] cmpv_reg, res_reg, sar_reg, sar_next;
  logic [3:0] bit_reg;
  logic [4:0] smp_reg;
  logic [2:0] div_reg;
  logic half_reg, trig_s1, trig_s2, trig_s3, pend_reg;
  logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic acc_pkg::acc_kind_t ch_kind(input logic [4:0] c);
    if (c <= acc_pkg::CH_EXT_LAST)
      return acc_pkg::K_EXT;
    else if (c <= acc_pkg::CH_GND_LAST)
      return acc_pkg::K_GND;
    else if (c == acc_pkg::CH_TEMP)
      return acc_pkg::K_TEMP;
    else if (c == acc_pkg::CH_BG)
      return acc_pkg::K_BG;
    else if (c == acc_pkg::CH_VREFH)
      return acc_pkg::K_VREFH;
    else if (c == acc_pkg::CH_VREFL)
      return acc_pkg::K_VREFL;
    else if (c == acc_pkg::CH_OFF)
      return acc_pkg::K_OFF;
    else
      return acc_pkg::K_RSVD;
  endfunction

  function automatic logic [ADDR_W-1:0] word(input logic [ADDR_W-1:0] a);
    return a & ~ADDR_W'(acc_pkg::ADDR_LSB_MASK);
  endfunction

  function automatic logic [31:0] reg_val(input logic [ADDR_W-1:0] a);
    if (word(a) == ADDR_W'(acc_pkg::OFF_SC1))
      return 32'(sc1_reg);
    else if (word(a) == ADDR_W'(acc_pkg::OFF_SC2))
      return 32'(sc2_reg);
    else if (word(a) == ADDR_W'(acc_pkg::OFF_RESHI))
      return 32'(res_reg >> 8);
    else if (word(a) == ADDR_W'(acc_pkg::OFF_RESLO))
      return 32'(res_reg[7:0]);
    else if (word(a) == ADDR_W'(acc_pkg::OFF_CMPV))
      return 32'(cmpv_reg);
    else if (word(a) == ADDR_W'(acc_pkg::OFF_CFG))
      return 32'(cfg_reg);
    else
      return 32'h0;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return word(a) <= ADDR_W'(acc_pkg::OFF_CFG);
  endfunction

  function automatic logic [9:0] bit_mask(input logic [3:0] i);
    return 10'h001 << i;
  endfunction

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  wire wr_fire = aw_full_reg && w_full_reg;
  wire ar_fire = ARVALID && ARREADY;
  wire [31:0] strb_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                           {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire [31:0] wd = (reg_val(waddr_reg) & ~strb_mask) |
                   (wdata_reg & strb_mask);
  wire [ADDR_W-1:0] wa = word(waddr_reg);
  wire sc1_wr = wr_fire && wa == ADDR_W'(acc_pkg::OFF_SC1);
  wire reslo_rd = ar_fire && word(ARADDR) == ADDR_W'(acc_pkg::OFF_RESLO);
  assign AWREADY = !aw_full_reg && !bvalid_reg;
  assign WREADY = !w_full_reg && !bvalid_reg;
  assign ARREADY = !rvalid_reg;
  assign BVALID = bvalid_reg;
  assign BRESP = bresp_reg;
  assign RVALID = rvalid_reg;
  assign RDATA = rdata_reg;
  assign RRESP = rresp_reg;

  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bresp_reg <= acc_pkg::RESP_OKAY;
    end
    else
    begin
      // address and data may come in either order
      if (AWVALID && AWREADY)
      begin
        aw_full_reg <= 1'b1;
        waddr_reg <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_full_reg <= 1'b1;
        wdata_reg <= WDATA;
        wstrb_reg <= WSTRB;
      end
      if (wr_fire)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(waddr_reg) ? acc_pkg::RESP_OKAY
                                       : acc_pkg::RESP_SLVERR;
      end
      else if (BREADY)
        bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= acc_pkg::RESP_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= reg_val(ARADDR);
      rresp_reg <= mapped(ARADDR) ? acc_pkg::RESP_OKAY
                                  : acc_pkg::RESP_SLVERR;
    end
    else if (RREADY)
      rvalid_reg <= 1'b0;
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      sc2_reg <= '0;
      cmpv_reg <= 10'h000;
      cfg_reg <= '0;
    end
    else
    begin
      // read-only status fields follow the block, not the bus
      sc2_reg.active <= state_reg != acc_pkg::S_IDLE;
      sc2_reg.bg_ok <= BANDGAP_BUF_EN;
      if (wr_fire && wa == ADDR_W'(acc_pkg::OFF_SC2))
      begin
        sc2_reg.hwtrig <= wd[6];
        sc2_reg.cmp_en <= wd[5];
        sc2_reg.cmp_ge <= wd[4];
      end
      else if (wr_fire && wa == ADDR_W'(acc_pkg::OFF_CMPV))
        cmpv_reg <= wd[9:0];
      else if (wr_fire && wa == ADDR_W'(acc_pkg::OFF_CFG))
        cfg_reg <= acc_pkg::acc_cfg_t'(wd[7:0]);
    end
  end

  // ----------------------------------------
  // conversion clock
  // ----------------------------------------
  // bus-derived and alternate sources are dead in stop3
  wire src_ok = !STOP3_MODE || cfg_reg.clk == acc_pkg::CLK_ASYNC;
  wire src_tick = cfg_reg.clk == acc_pkg::CLK_BUS ? 1'b1 :
                  cfg_reg.clk == acc_pkg::CLK_BUS2 ? half_reg :
                  cfg_reg.clk == acc_pkg::CLK_ALT ? ALT_TICK :
                  ASYNC_TICK;
  wire [2:0] div_lim = 3'((4'h1 << cfg_reg.div) - 4'h1);
  wire src_en = src_tick && src_ok;
  wire conv_tick = src_en && div_reg == div_lim;

  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      half_reg <= 1'b0;
      div_reg <= 3'h0;
    end
    else
    begin
      half_reg <= !half_reg;
      if (src_en)
        div_reg <= conv_tick ? 3'h0 : div_reg + 3'h1;
    end
  end

  // ----------------------------------------
  // hardware trigger
  // ----------------------------------------
  // trigger is taken with no interrupt-enable gating, in any power mode
  wire trig_edge = trig_s2 && !trig_s3;
  wire ch_on = sc1_reg.ch != acc_pkg::CH_OFF;
  wire hw_start = pend_reg && state_reg == acc_pkg::S_IDLE && ch_on &&
                  !sc1_wr;

  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
      pend_reg <= 1'b0;
    end
    else
    begin
      trig_s1 <= HW_TRIG;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
      // a new overflow wins over the consume of the previous one
      if (trig_edge && sc2_reg.hwtrig)
        pend_reg <= 1'b1;
      else if (hw_start || !sc2_reg.hwtrig)
        pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  wire [4:0] new_ch = wd[4:0];
  wire sw_start = sc1_wr && !sc2_reg.hwtrig &&
                  new_ch != acc_pkg::CH_OFF;
  wire [4:0] smp_lim = cfg_reg.long_smp ? acc_pkg::SMP_LONG_LIM
                                        : acc_pkg::SMP_SHORT_LIM;
  wire last_bit = bit_reg == 4'h0;
  wire conv_done = state_reg == acc_pkg::S_CONV && conv_tick && last_bit &&
                   !sc1_wr;
  wire [9:0] keep = CMP_IN ? sar_reg : sar_reg & ~bit_mask(bit_reg);
  wire [9:0] res_fmt = cfg_reg.res10 ? keep
                                     : keep >> acc_pkg::RES_DROP;
  wire [9:0] cv_fmt = cfg_reg.res10 ? cmpv_reg
                                    : cmpv_reg & acc_pkg::LOW8_MASK;
  wire hit = sc2_reg.cmp_ge ? res_fmt >= cv_fmt : res_fmt < cv_fmt;
  wire conversion_complete_flag_set = conv_done && (!sc2_reg.cmp_en || hit);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      acc_pkg::S_IDLE:
        if (hw_start)
          state_next = acc_pkg::S_SAMPLE;
      acc_pkg::S_SAMPLE:
        if (conv_tick && smp_reg == smp_lim)
          state_next = acc_pkg::S_CONV;
      acc_pkg::S_CONV:
        if (conv_done)
          state_next = sc1_reg.cont && ch_on ? acc_pkg::S_SAMPLE
                                             : acc_pkg::S_IDLE;
      default:
        state_next = acc_pkg::S_IDLE;
    endcase
    if (sc1_wr)
      state_next = sw_start ? acc_pkg::S_SAMPLE : acc_pkg::S_IDLE;
  end

  always_comb
  begin
    sar_next = sar_reg;
    if (state_reg == acc_pkg::S_SAMPLE)
      sar_next = acc_pkg::SAR_MSB;
    else if (state_reg == acc_pkg::S_CONV && conv_tick)
      sar_next = last_bit ? keep : keep | bit_mask(bit_reg - 4'h1);
  end

  always_comb
  begin
    sc1_next = sc1_reg;
    if (sc1_wr)
    begin
      sc1_next = acc_pkg::acc_sc1_t'(wd[7:0]);
      sc1_next.conversion_complete_flag = 1'b0;
    end
    if (reslo_rd)
      sc1_next.conversion_complete_flag = 1'b0;
    if (conversion_complete_flag_set)
      sc1_next.conversion_complete_flag = 1'b1;
  end

  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_reg <= acc_pkg::S_IDLE;
      sc1_reg <= '{conversion_complete_flag: 1'b0, aien: 1'b0, cont: 1'b0, ch: acc_pkg::CH_OFF};
      sar_reg <= 10'h000;
      bit_reg <= acc_pkg::BIT_TOP;
      smp_reg <= 5'h00;
      res_reg <= 10'h000;
    end
    else
    begin
      state_reg <= state_next;
      sc1_reg <= sc1_next;
      sar_reg <= sar_next;
      if (state_reg != acc_pkg::S_CONV)
        bit_reg <= acc_pkg::BIT_TOP;
      else if (conv_tick && !last_bit)
        bit_reg <= bit_reg - 4'h1;
      if (state_reg != acc_pkg::S_SAMPLE)
        smp_reg <= 5'h00;
      else if (conv_tick)
        smp_reg <= smp_reg + 5'h01;
      // result only replaced when the flag would set
      if (conversion_complete_flag_set)
        res_reg <= res_fmt;
    end
  end

  // ----------------------------------------
  // analog side
  // ----------------------------------------
  // reserved codes reach the mux as is; their result is meaningless
  assign AN_SEL = sc1_reg.ch;
  assign AN_KIND = ch_kind(sc1_reg.ch);
  assign AN_CONNECT = ch_on;
  assign AN_SAMPLE = state_reg == acc_pkg::S_SAMPLE;
  assign DAC_CODE = sar_reg;
  assign LOW_POWER = cfg_reg.low_power;
  assign IRQ = sc1_reg.conversion_complete_flag && sc1_reg.aien;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  sequence s_ctl_write;
    sc1_wr;
  endsequence
  sequence s_last_step;
    conv_done ##0 !sc2_reg.cmp_en;
  endsequence
  a_write_aborts: assert property (s_ctl_write |=>
    state_reg != acc_pkg::S_CONV) else $error("control write no abort");
  a_off_no_start: assert property (s_ctl_write ##0 !sw_start |=>
    state_reg == acc_pkg::S_IDLE) else $error("off code started");
  a_flag_on_done: assert property (s_last_step |=>
    sc1_reg.conversion_complete_flag && res_reg == $past(res_fmt)) else $error("flag not set");
  a_flag_clear: assert property (reslo_rd && !conv_done |=>
    !sc1_reg.conversion_complete_flag) else $error("flag not cleared");
  a_single_idle: assert property (conv_done && !sc1_reg.cont |=>
    state_reg == acc_pkg::S_IDLE) else $error("single not idle");
  a_isolate_off: assert property (sc1_reg.ch == acc_pkg::CH_OFF |->
    !AN_CONNECT && AN_KIND == acc_pkg::K_OFF) else $error("not isolated");
  a_trig_start: assert property (hw_start |=>
    state_reg == acc_pkg::S_SAMPLE ##1 !pend_reg || $past(trig_edge))
    else $error("trigger not taken");
  a_irq_follow: assert property (conversion_complete_flag_set && sc1_reg.aien |=>
    IRQ) else $error("irq missing");
  a_cmp_block: assert property (conv_done && sc2_reg.cmp_en && !hit &&
    !sc1_reg.conversion_complete_flag && !reslo_rd |=> !sc1_reg.conversion_complete_flag) else $error("false hit");
endmodule

/* File: test/acc_an_model.sv */
// analog side stand-in: ideal comparator on the routed source
`timescale 1ns/100ps
module acc_an_model (
  input wire logic clk,
  input wire logic [4:0] an_sel,
  input wire logic [2:0] an_kind,
  input wire logic an_connect,
  input wire logic [9:0] dac_code,
  output logic cmp_in
);
  logic [9:0] level;
  logic flip = 1'b0;
  // ----------------------------------------
  // source levels per routed input
  // ----------------------------------------
  assign level = (an_kind == acc_pkg::K_EXT) ? {an_sel[3:0], 6'h15} :
    (an_kind == acc_pkg::K_TEMP) ? 10'h1c3 :
    (an_kind == acc_pkg::K_BG) ? 10'h26e :
    (an_kind == acc_pkg::K_VREFH) ? 10'h3ff :
    (an_kind == acc_pkg::K_RSVD) ? 10'h0a5 : 10'h000;
  // isolated input floats: toggle so no stale level looks valid
  always @(posedge clk)
    flip <= !flip;
  assign cmp_in = an_connect ? (level >= dac_code) : flip;
endmodule

/* File: test/acc_ctrl_tb.sv */
// self-checking bench for the converter control block
`timescale 1ns/100ps
module acc_ctrl_tb;
  logic clock, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic async_tick, alt_tick, stop3, hw_trig, bg_en, cmp_in;
  logic awready, wready, bvalid, arready, rvalid, an_connect;
  logic an_sample, low_power, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv, hi;
  logic [1:0] bresp, rresp, rs;
  logic [1:0] tc = 2'h0;
  logic [4:0] an_sel;
  logic [2:0] an_kind;
  logic [9:0] dac_code;
  logic [4:0] chs [7] = '{5'h00, 5'h05, 5'h0f, 5'h10, 5'h15, 5'h1d, 5'h1e};
  logic [9:0] cmpv [4] = '{10'h3ff, 10'h100, 10'h100, 10'h200};
  logic cexp [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  int error_cnt = 0;
  int checks_done = 0;

  acc_ctrl uut (.CLOCK(clock), .SYS_RST(sys_rst), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .ASYNC_TICK(async_tick), .ALT_TICK(alt_tick), .STOP3_MODE(stop3),
    .HW_TRIG(hw_trig), .BANDGAP_BUF_EN(bg_en), .CMP_IN(cmp_in),
    .AN_SEL(an_sel), .AN_KIND(an_kind), .AN_CONNECT(an_connect),
    .AN_SAMPLE(an_sample), .DAC_CODE(dac_code), .LOW_POWER(low_power),
    .IRQ(irq));
  acc_an_model model (.clk(clock), .an_sel(an_sel), .an_kind(an_kind),
    .an_connect(an_connect), .dac_code(dac_code), .cmp_in(cmp_in));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = !clock;
  end
  // local and alternate clock edges, each every third cycle, one cycle apart
  always @(posedge clock)
  begin
    tc <= (tc == 2'h2) ? 2'h0 : tc + 2'h1;
    async_tick <= (tc == 2'h0);
    alt_tick <= (tc == 2'h1);
  end
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // handshakes sampled at the falling edge, acted on at the next rise
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    int n;
    b_ok = 1'b0;
    n = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok && n < 200)
    begin
      @(negedge clock);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      rs = bresp;
      n++;
      @(posedge clock);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!b_ok) error_cnt++;
  endtask
  task automatic bus_rd(input logic [7:0] a);
    logic ar_ok, r_ok;
    int n;
    r_ok = 1'b0;
    n = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok && n < 200)
    begin
      @(negedge clock);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      rv = rdata;
      rs = rresp;
      n++;
      @(posedge clock);
      if (ar_ok) arvalid <= 1'b0;
    end
    arvalid <= 1'b0;
    rready <= 1'b0;
    if (!r_ok) error_cnt++;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    bus_rd(acc_pkg::OFF_SC1);
    // slowest setting (divided local clock, long sample) needs ~410 cycles
    while (rv[7] !== 1'b1 && n < 250)
    begin
      bus_rd(acc_pkg::OFF_SC1);
      n++;
    end
  endtask
  task automatic idle_conversion_complete_flag(input string what);
    repeat (150) @(posedge clock);
    bus_rd(acc_pkg::OFF_SC1);
    chk(what, rv[7], 1'b0);
  endtask
  task automatic conv(input logic [4:0] ch, input logic [9:0] exp);
    bus_wr(acc_pkg::OFF_SC1, {27'h0, ch});
    wait_done();
    chk("complete flag", rv[7], 1'b1);
    bus_rd(acc_pkg::OFF_RESHI);
    hi = rv;
    bus_rd(acc_pkg::OFF_RESLO);
    chk("result", {hi[1:0], rv[7:0]}, exp);
  endtask
  function automatic logic [9:0] lvl(input logic [4:0] c);
    return (c <= 5'h0f) ? {c[3:0], 6'h15} : (c == 5'h1d) ? 10'h3ff : 10'h0;
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    {sys_rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {stop3, hw_trig, bg_en} = 3'h0;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    bus_rd(acc_pkg::OFF_SC1);
    chk("sc1 reset", rv, 32'h1f);
    chk("isolated", an_connect, 1'b0);
    bus_rd(8'h40);
    chk("unmapped data", rv, 32'h0);
    chk("unmapped rresp", rs, acc_pkg::RESP_SLVERR);
    bus_wr(8'h40, 32'h5a);
    chk("unmapped bresp", rs, acc_pkg::RESP_SLVERR);
    bus_wr(acc_pkg::OFF_CFG, 32'h08);
    for (int i = 0; i < 7; i++)
    begin
      conv(chs[i], lvl(chs[i]));
      chk("trial word", dac_code, lvl(chs[i]));
      chk("routed code", an_sel, chs[i]);
    end
    for (int s = 0; s < 4; s++)
    begin
      bus_wr(acc_pkg::OFF_CFG, 32'h08 | s | (s << 5));
      conv(5'h07, lvl(5'h07));
    end
    bus_wr(acc_pkg::OFF_CFG, 32'h00);
    conv(5'h0a, lvl(5'h0a) >> 2);
    // divide by four keeps the local clock under the temperature limit
    bus_wr(acc_pkg::OFF_CFG, 32'h5b);
    bg_en <= 1'b1;
    conv(5'h1b, 10'h26e);
    conv(5'h1a, 10'h1c3);
    chk("temp kind", an_kind, acc_pkg::K_TEMP);
    bus_rd(acc_pkg::OFF_SC2);
    chk("bandgap mirror", rv[0], 1'b1);
    stop3 <= 1'b1;
    conv(5'h03, lvl(5'h03));
    stop3 <= 1'b0;
    bus_wr(acc_pkg::OFF_CFG, 32'h88);
    chk("low power", low_power, 1'b1);
    bus_wr(acc_pkg::OFF_CFG, 32'h08);
    bus_wr(acc_pkg::OFF_SC1, 32'h16);
    wait_done();
    chk("reserved converts", rv[7], 1'b1);
    bus_wr(acc_pkg::OFF_SC1, 32'h03);
    conv(5'h1d, 10'h3ff);
    bus_wr(acc_pkg::OFF_SC1, 32'h1f);
    chk("off kind", an_kind, acc_pkg::K_OFF);
    idle_conversion_complete_flag("off no start");
    bus_wr(acc_pkg::OFF_SC1, 32'h45);
    wait_done();
    chk("irq", irq, 1'b1);
    bus_rd(acc_pkg::OFF_RESLO);
    bus_rd(acc_pkg::OFF_SC1);
    chk("flag read clear", rv[7], 1'b0);
    chk("irq clear", irq, 1'b0);
    idle_conversion_complete_flag("single idle");
    bus_wr(acc_pkg::OFF_SC1, 32'h25);
    wait_done();
    bus_rd(acc_pkg::OFF_RESLO);
    wait_done();
    chk("continuous", rv[7], 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      bus_wr(acc_pkg::OFF_SC2, (k < 2) ? 32'h30 : 32'h20);
      bus_wr(acc_pkg::OFF_CMPV, {22'h0, cmpv[k]});
      bus_wr(acc_pkg::OFF_SC1, 32'h05);
      repeat (100) @(posedge clock);
      bus_rd(acc_pkg::OFF_SC1);
      chk("compare flag", rv[7], cexp[k]);
    end
    bus_wr(acc_pkg::OFF_SC2, 32'h40);
    for (int m = 0; m < 2; m++)
    begin
      bus_wr(acc_pkg::OFF_CFG, m ? 32'h0b : 32'h08);
      stop3 <= m[0];
      bus_wr(acc_pkg::OFF_SC1, 32'h05);
      idle_conversion_complete_flag("hw waits");
      chk("no sampling", an_sample, 1'b0);
      hw_trig <= 1'b1;
      repeat (20) @(posedge clock);
      hw_trig <= 1'b0;
      wait_done();
      chk("hw start", rv[7], 1'b1);
      bus_rd(acc_pkg::OFF_RESLO);
      idle_conversion_complete_flag("one per edge");
    end
    print_verdict();
  end
  initial
  begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    print_verdict();
  end
endmodule
